//--- rtl/dma_cfg_pkg.sv
package dma_cfg_pkg;
	localparam int CHANNELS = 6;
	localparam int REQUESTS = 16;
	localparam int CH_MSB = 7;
	localparam int CH_LSB = 5;
	localparam logic [4:0] OFS_CONFIG = 5'h00;
	localparam logic [4:0] OFS_CONTROL = 5'h04;
	localparam logic [4:0] OFS_A_START = 5'h08;
	localparam logic [4:0] OFS_B_START = 5'h0C;
	localparam logic [4:0] OFS_A_COUNT = 5'h10;
	localparam logic [4:0] OFS_B_COUNT = 5'h14;
	localparam int RUN_BIT = 0;
	localparam logic [3:0] CONFIG_TOP_RESET = 4'h0;
	localparam logic [3:0] LAST_BEAT_SHORT = 4'h3;
	localparam logic [3:0] LAST_BEAT_LONG = 4'h7;
	localparam logic [31:0] WORD_BYTES = 32'h4;

	// Field order matches bit positions 31 down to 0
	typedef struct packed {
		logic [3:0] port_hi;
		logic [19:0] port_lo;
		logic [3:0] request_select;
		logic datum_width_select;
		logic burst_length_select;
		logic big_endian;
		logic direction;
	} device_config_t;

	typedef struct packed {
		logic [31:0] address;
		logic [15:0] data;
		logic half;
	} datum_t;

	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_FETCH = 5'h02,
		S_DELIVER = 5'h04,
		S_COLLECT = 5'h08,
		S_STORE = 5'h10
	} state_t;

	function automatic logic [31:0] port_address(device_config_t c);
		return {c.port_hi, 6'h00, c.port_lo, 2'h0};
	endfunction: port_address

	function automatic logic [2:0] words_in_burst(device_config_t c);
		case ({c.burst_length_select, c.datum_width_select})
			2'b00: return 3'h1;
			2'b11: return 3'h4;
			default: return 3'h2;
		endcase
	endfunction: words_in_burst
endpackage: dma_cfg_pkg

//--- rtl/dma_channel_device_config.sv
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
// What this block, its driver software and its peripherals do
// R1: Six channels each hold device config, control/status, two start and two count words of 32 bits.
// R2: Config bit 0 set means peripheral to memory, clear means memory to peripheral.
// R3: Config bit 1 picks big endian lane order in memory words, clear picks little endian.
// R4: Config bit 2 picks eight datums per burst, clear picks four.
// R5: Config bit 3 picks half-word datums, clear picks bytes.
// R6: Each granted request moves exactly one burst of the programmed beats and datum size.
// R7: Bits 7:4 choose the one request line a channel answers; other lines are ignored.
// R8: The port address is field 31:28 on 31:28, field 27:8 on 21:2, zeros elsewhere.
// R9: Reset clears config bits 31:28 only; the other bits keep no defined value.
// R10: Request codes pair up per peripheral, even codes transmit and odd codes receive.
// R11: Software sets half-word width for codec and synchronous port codes, byte otherwise.
// R12: Software sets eight-beat bursts for the USB and high speed port codes, four otherwise.
// R13: Software sets direction 0 for even codes and 1 for odd codes.
// R14: Config writes take effect only while the channel run bit is clear.
// R15: Memory to peripheral bursts are fetched as whole words, then sent datum by datum.
// R16: A peripheral raises its request at its FIFO threshold, and that starts a burst.
// R17: Reading the config returns the last accepted value of every field.
module dma_channel_device_config #(
	parameter int CHANNELS = dma_cfg_pkg::CHANNELS
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// Peripheral requests, one line per request code
	input wire logic [dma_cfg_pkg::REQUESTS-1:0] dma_request,
	// Memory word read stream
	input wire logic mem_in_valid,
	output logic mem_in_ready,
	input wire logic [31:0] mem_in_data,
	// Memory word write stream
	output logic mem_out_valid,
	input wire logic mem_out_ready,
	output logic [31:0] mem_out_data,
	output logic [31:0] mem_addr,
	// Datums toward the peripheral
	output logic per_out_valid,
	input wire logic per_out_ready,
	output dma_cfg_pkg::datum_t per_out,
	// Datums from the peripheral
	input wire logic per_in_valid,
	output logic per_in_ready,
	input wire logic [15:0] per_in_data,
	output logic [31:0] per_in_address,
	// Engine status
	output logic busy
);
	if (CHANNELS < 1 || CHANNELS > 8) begin: g_check
		$error("CHANNELS must be 1 to 8");
	end

	function automatic logic [1:0] mem_lane(logic [1:0] lane, logic dw, logic e);
		if (!e)
			return lane; // R3
		return dw ? {1'b0, ~lane[0]} : ~lane; // R3
	endfunction: mem_lane

	// Register storage
	logic [3:0] cfg_top [CHANNELS]; // R1
	logic [27:0] cfg_low [CHANNELS];
	dma_cfg_pkg::device_config_t cfg [CHANNELS];
	logic [CHANNELS-1:0] run;
	logic [31:0] start_a [CHANNELS];
	logic [31:0] start_b [CHANNELS];
	logic [31:0] count_a [CHANNELS];
	logic [31:0] count_b [CHANNELS];
	logic [31:0] ptr [CHANNELS];

	// Engine state
	dma_cfg_pkg::state_t state;
	dma_cfg_pkg::state_t next_state;
	logic [2:0] ch;
	logic [3:0] beat;
	logic [2:0] wcnt;
	logic [31:0] wbuf [4];

	// Two-entry peripheral buffer
	dma_cfg_pkg::datum_t q [2];
	logic wr_sel;
	logic rd_sel;
	logic [1:0] fill;
	logic [1:0] next_fill;

	// Bus decode
	wire [4:0] ofs = reg_addr[4:0];
	wire ch_ok = {1'b0, reg_addr[dma_cfg_pkg::CH_MSB:dma_cfg_pkg::CH_LSB]} < 4'(CHANNELS);
	wire [2:0] sel = ch_ok ? reg_addr[dma_cfg_pkg::CH_MSB:dma_cfg_pkg::CH_LSB] : 3'h0;
	wire wr_ok = reg_write && ch_ok;
	wire [31:0] sel_cfg = cfg[sel];
	wire [31:0] read_value =
		!ch_ok ? 32'h0 :
		ofs == dma_cfg_pkg::OFS_CONFIG ? sel_cfg :
		ofs == dma_cfg_pkg::OFS_CONTROL ? {31'h0, run[sel]} :
		ofs == dma_cfg_pkg::OFS_A_START ? start_a[sel] :
		ofs == dma_cfg_pkg::OFS_B_START ? start_b[sel] :
		ofs == dma_cfg_pkg::OFS_A_COUNT ? count_a[sel] :
		ofs == dma_cfg_pkg::OFS_B_COUNT ? count_b[sel] : 32'h0;

	// Active channel decode
	dma_cfg_pkg::device_config_t act;
	assign act = cfg[ch];
	wire [3:0] last_beat = act.burst_length_select ?
		dma_cfg_pkg::LAST_BEAT_LONG : dma_cfg_pkg::LAST_BEAT_SHORT; // R4 R6
	wire [2:0] last_word = dma_cfg_pkg::words_in_burst(act) - 3'h1; // R6
	wire [1:0] beat_word = act.datum_width_select ? beat[2:1] : {1'b0, beat[2]};
	wire [1:0] beat_lane = act.datum_width_select ? {1'b0, beat[0]} : beat[1:0];
	wire [1:0] lane = mem_lane(beat_lane, act.datum_width_select, act.big_endian);
	wire [31:0] cur_word = wbuf[beat_word];

	// Grant: lowest numbered running channel whose own request line is up
	wire [CHANNELS-1:0] wants;
	logic grant_valid;
	logic [2:0] grant_ch;
	for (genvar g = 0; g < CHANNELS; g++) begin: g_ch
		assign cfg[g] = {cfg_top[g], cfg_low[g]};
		assign wants[g] = run[g] && dma_request[cfg[g].request_select]; // R7 R10 R16
	end
	always_comb begin
		grant_valid = 1'b0;
		grant_ch = 3'h0;
		for (int c = CHANNELS - 1; c >= 0; c--) begin
			if (wants[c]) begin
				grant_valid = 1'b1;
				grant_ch = 3'(c);
			end
		end
	end

	// Handshakes
	wire in_idle = state == dma_cfg_pkg::S_IDLE;
	wire q_ready = fill != 2'h2;
	wire push = state == dma_cfg_pkg::S_DELIVER && q_ready;
	wire pop = per_out_valid && per_out_ready;
	wire fetch_fire = mem_in_valid && mem_in_ready;
	wire store_fire = mem_out_valid && mem_out_ready;
	wire collect_fire = per_in_valid && per_in_ready;
	assign mem_in_ready = state == dma_cfg_pkg::S_FETCH;
	assign per_in_ready = state == dma_cfg_pkg::S_COLLECT;
	assign mem_out_valid = state == dma_cfg_pkg::S_STORE;
	assign mem_out_data = wbuf[wcnt[1:0]];
	assign per_in_address = dma_cfg_pkg::port_address(act); // R8
	assign busy = !in_idle;
	assign per_out_valid = fill != 2'h0;
	assign per_out = q[rd_sel];
	assign next_fill = fill + {1'b0, push} - {1'b0, pop};

	wire [15:0] push_data = act.datum_width_select ?
		(lane[0] ? cur_word[31:16] : cur_word[15:0]) :
		{8'h00, cur_word[8*lane +: 8]}; // R5 R15
	dma_cfg_pkg::datum_t push_datum;
	assign push_datum = {dma_cfg_pkg::port_address(act), push_data, act.datum_width_select}; // R5 R8

	always_comb begin
		next_state = state;
		unique case (state)
			dma_cfg_pkg::S_IDLE:
				if (grant_valid)
					next_state = cfg[grant_ch].direction ?
						dma_cfg_pkg::S_COLLECT : dma_cfg_pkg::S_FETCH; // R2
			dma_cfg_pkg::S_FETCH:
				if (fetch_fire && wcnt == last_word)
					next_state = dma_cfg_pkg::S_DELIVER; // R15
			dma_cfg_pkg::S_DELIVER:
				if (push && beat == last_beat)
					next_state = dma_cfg_pkg::S_IDLE; // R6
			dma_cfg_pkg::S_COLLECT:
				if (collect_fire && beat == last_beat)
					next_state = dma_cfg_pkg::S_STORE; // R6
			dma_cfg_pkg::S_STORE:
				if (store_fire && wcnt == last_word)
					next_state = dma_cfg_pkg::S_IDLE;
		endcase
	end

	// Top nibble only is reset; the rest stays as it powers up
	always_ff @(posedge mclk) begin
		for (int c = 0; c < CHANNELS; c++) begin
			if (reset)
				cfg_top[c] <= dma_cfg_pkg::CONFIG_TOP_RESET; // R9
			else if (wr_ok && sel == 3'(c) && ofs == dma_cfg_pkg::OFS_CONFIG && !run[c])
				cfg_top[c] <= reg_wdata[31:28]; // R14
		end
	end

	always_ff @(posedge mclk) begin
		for (int c = 0; c < CHANNELS; c++) begin
			if (wr_ok && sel == 3'(c) && ofs == dma_cfg_pkg::OFS_CONFIG && !run[c])
				cfg_low[c] <= reg_wdata[27:0]; // R14
		end
	end

	always_ff @(posedge mclk) begin
		for (int c = 0; c < CHANNELS; c++) begin
			if (wr_ok && sel == 3'(c) && ofs == dma_cfg_pkg::OFS_B_START)
				start_b[c] <= reg_wdata;
			if (wr_ok && sel == 3'(c) && ofs == dma_cfg_pkg::OFS_A_COUNT)
				count_a[c] <= reg_wdata;
			if (wr_ok && sel == 3'(c) && ofs == dma_cfg_pkg::OFS_B_COUNT)
				count_b[c] <= reg_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			run <= '0;
			reg_rdata <= 32'h0;
		end else begin
			reg_rdata <= reg_read ? read_value : 32'h0; // R17
			for (int c = 0; c < CHANNELS; c++)
				if (wr_ok && sel == 3'(c) && ofs == dma_cfg_pkg::OFS_CONTROL)
					run[c] <= reg_wdata[dma_cfg_pkg::RUN_BIT];
		end
	end

	// A start writes also rewind the channel's memory pointer
	always_ff @(posedge mclk) begin
		for (int c = 0; c < CHANNELS; c++) begin
			if (reset) begin
				start_a[c] <= 32'h0;
				ptr[c] <= 32'h0;
			end else if (wr_ok && sel == 3'(c) && ofs == dma_cfg_pkg::OFS_A_START) begin
				start_a[c] <= reg_wdata;
				ptr[c] <= reg_wdata;
			end else if (ch == 3'(c) && !in_idle && next_state == dma_cfg_pkg::S_IDLE) begin
				ptr[c] <= state == dma_cfg_pkg::S_STORE ? mem_addr + dma_cfg_pkg::WORD_BYTES : mem_addr;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			state <= dma_cfg_pkg::S_IDLE;
			ch <= 3'h0;
			beat <= 4'h0;
			wcnt <= 3'h0;
			mem_addr <= 32'h0;
		end else begin
			state <= next_state;
			if (in_idle && grant_valid) begin
				ch <= grant_ch; // R7
				beat <= 4'h0;
				wcnt <= 3'h0;
				mem_addr <= ptr[grant_ch];
			end
			if (fetch_fire || store_fire) begin
				wcnt <= wcnt + 3'h1;
				if (!(state == dma_cfg_pkg::S_STORE && wcnt == last_word))
					mem_addr <= mem_addr + dma_cfg_pkg::WORD_BYTES; // R15
			end
			if (push || collect_fire)
				beat <= beat + 4'h1; // R6
			if (collect_fire && beat == last_beat)
				wcnt <= 3'h0;
		end
	end

	// Word buffer: filled from memory, or packed from peripheral datums
	always_ff @(posedge mclk) begin
		if (fetch_fire)
			wbuf[wcnt[1:0]] <= mem_in_data; // R15
		if (collect_fire) begin
			if (act.datum_width_select)
				wbuf[beat_word][16*lane[0] +: 16] <= per_in_data; // R3 R5
			else
				wbuf[beat_word][8*lane +: 8] <= per_in_data[7:0]; // R3
		end
	end

	// A receiver stall holds the two entries; the engine waits on q_ready
	always_ff @(posedge mclk) begin
		if (reset) begin
			fill <= 2'h0;
			wr_sel <= 1'b0;
			rd_sel <= 1'b0;
		end else begin
			fill <= next_fill;
			if (push)
				wr_sel <= ~wr_sel;
			if (pop)
				rd_sel <= ~rd_sel;
		end
	end

	always_ff @(posedge mclk) begin
		if (push)
			q[wr_sel] <= push_datum;
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (reset);

	sequence seq_locked_write;
		reg_write && ch_ok && ofs == dma_cfg_pkg::OFS_CONFIG && run[sel];
	endsequence
	sequence seq_config_read;
		reg_read && ch_ok && ofs == dma_cfg_pkg::OFS_CONFIG;
	endsequence

	a_locked_config: assert property (seq_locked_write |=> sel_cfg == $past(sel_cfg)) // R14
		else $error("config changed while running");
	a_top_reset: assert property (@(posedge mclk) disable iff (1'b0) reset |=> cfg_top[0] == 4'h0) // R9
		else $error("config top nibble not cleared");
	a_config_readback: assert property (seq_config_read ##0 !reg_write |=> reg_rdata === $past(sel_cfg)) // R17
		else $error("config read mismatch");
	a_grant_request: assert property (in_idle && grant_valid |-> dma_request[cfg[grant_ch].request_select]) // R7
		else $error("grant without matching request");
	a_direction_path: assert property (in_idle && grant_valid && cfg[grant_ch].direction // R2
		|=> state == dma_cfg_pkg::S_COLLECT)
		else $error("read direction did not collect");
	a_burst_beats: assert property (state == dma_cfg_pkg::S_DELIVER && push // R4
		|-> beat <= (act.burst_length_select ? dma_cfg_pkg::LAST_BEAT_LONG : dma_cfg_pkg::LAST_BEAT_SHORT))
		else $error("burst ran past its beat count");
	a_fetch_words: assert property ($rose(state == dma_cfg_pkg::S_DELIVER) // R15
		|-> wcnt == dma_cfg_pkg::words_in_burst(act))
		else $error("deliver before all words fetched");
	a_burst_ends: assert property (state == dma_cfg_pkg::S_DELIVER && push && beat == last_beat // R6
		|=> in_idle)
		else $error("burst did not end after last beat");
	a_datum_width: assert property (push |-> push_datum.half == act.datum_width_select // R5
		&& (act.datum_width_select || push_datum.data[15:8] == 8'h00))
		else $error("datum width mismatch");
	a_port_zero: assert property (push |-> push_datum.address[27:22] == 6'h00 // R8
		&& push_datum.address[1:0] == 2'h0)
		else $error("port address zero bits set");
	a_buffer_bound: assert property (fill == 2'h2 |-> !push ##1 fill != 2'h3)
		else $error("peripheral buffer overrun");
endmodule: dma_channel_device_config

//--- tb/periph_model.sv
`timescale 1ns/100ps
// Serial controllers: one request line, a drain that stalls every other cycle,
// and received datums that carry their own sequence number
module periph_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Bench control
	input wire logic [3:0] req_code,
	input wire logic req_go,
	// Toward the block
	output logic [15:0] dma_request,
	output logic per_out_ready,
	output logic per_in_valid,
	output logic [15:0] per_in_data,
	input wire logic per_in_ready,
	// Received datum count
	output logic [7:0] in_count
);
	assign dma_request = req_go ? 16'h0001 << req_code : 16'h0000;
	assign per_in_valid = 1'b1;
	assign per_in_data = {8'hA5, in_count};
	always_ff @(posedge mclk) begin
		if (reset) begin
			per_out_ready <= 1'b0;
			in_count <= 8'h00;
		end else begin
			per_out_ready <= ~per_out_ready;
			if (per_in_valid && per_in_ready)
				in_count <= in_count + 8'h01;
		end
	end
endmodule: periph_model

//--- tb/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [31:0] reg_rdata, mem_out_data, mem_addr, per_in_address, rv;
	logic [15:0] dma_request, per_in_data;
	logic mem_out_valid, mem_in_ready, per_out_valid, per_out_ready, per_in_valid, per_in_ready, busy;
	dma_cfg_pkg::datum_t per_out;
	logic [3:0] req_code = 4'h0;
	logic req_go = 1'b0;
	logic [7:0] in_count;
	int fail_count = 0;
	int comparisons = 0;
	int cycles = 0;
	dma_cfg_pkg::datum_t oq[$];
	logic [31:0] wq[$];
	logic [31:0] aq[$];

	always #20 mclk = ~mclk;

	dma_channel_device_config dma_channel_device_config_inst (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.dma_request(dma_request), .mem_in_valid(1'b1), .mem_in_ready(mem_in_ready),
		.mem_in_data(mem_addr ^ 32'h44332211),
		.mem_out_valid(mem_out_valid), .mem_out_ready(1'b1), .mem_out_data(mem_out_data), .mem_addr(mem_addr),
		.per_out_valid(per_out_valid), .per_out_ready(per_out_ready), .per_out(per_out),
		.per_in_valid(per_in_valid), .per_in_ready(per_in_ready), .per_in_data(per_in_data),
		.per_in_address(per_in_address), .busy(busy));

	periph_model periph_model_inst (.mclk(mclk), .reset(reset), .req_code(req_code), .req_go(req_go),
		.dma_request(dma_request), .per_out_ready(per_out_ready), .per_in_valid(per_in_valid),
		.per_in_data(per_in_data), .per_in_ready(per_in_ready), .in_count(in_count));

	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (per_out_valid && per_out_ready)
			oq.push_back(per_out);
		if (mem_out_valid)
			wq.push_back(mem_out_data);
		if (mem_out_valid || mem_in_ready)
			aq.push_back(mem_addr);
		if (cycles == 20000) begin
			fail_count++;
			give_verdict();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask: chk

	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask: give_verdict

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
	endtask: wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask: rd

	// Settings a correct driver would use for each request code
	function automatic dma_cfg_pkg::device_config_t mk(input logic [3:0] code, input logic e);
		mk = '0;
		mk.port_hi = 4'h8;
		mk.port_lo = {16'h0, code} + 20'h00005;
		mk.request_select = code;
		mk.datum_width_select = code >= 4'hA;
		mk.burst_length_select = code < 4'h2;
		mk.big_endian = e;
		mk.direction = code[0];
	endfunction: mk

	task automatic check_regs();
		rd(8'h00, rv);
		chk({28'h0, rv[31:28]}, 32'h0);
		for (int ch = 0; ch < 6; ch++) begin
			wr({3'(ch), 5'h00}, 32'h9ABCDEF0 ^ ch);
			rd({3'(ch), 5'h00}, rv);
			chk(rv, 32'h9ABCDEF0 ^ ch);
		end
		wr(8'hC0, 32'hFFFFFFFF);
		rd(8'hC0, rv);
		chk(rv, 32'h0);
	endtask: check_regs

	// A running channel must keep its old settings
	task automatic check_lock();
		wr(8'h40, 32'h11111111);
		wr(8'h44, 32'h1);
		wr(8'h40, 32'h22222222);
		rd(8'h40, rv);
		chk(rv, 32'h11111111);
		wr(8'h44, 32'h0);
		wr(8'h40, 32'h22222222);
		rd(8'h40, rv);
		chk(rv, 32'h22222222);
	endtask: check_lock

	task automatic burst(input logic [3:0] code, input logic e);
		dma_cfg_pkg::device_config_t c;
		logic [2:0] ch;
		logic [7:0] first, b;
		logic [31:0] word, sh;
		int n, beats, k, lane;
		c = mk(code, e);
		ch = 3'(code % 4'h6);
		n = c.datum_width_select ? 2 : 4;
		beats = c.burst_length_select ? 8 : 4;
		wr({ch, dma_cfg_pkg::OFS_CONFIG}, c);
		wr({ch, dma_cfg_pkg::OFS_A_START}, 32'h100);
		wr({ch, dma_cfg_pkg::OFS_CONTROL}, 32'h1);
		oq.delete();
		wq.delete();
		aq.delete();
		first = in_count;
		req_code <= code ^ 4'h1;
		req_go <= 1'b1;
		repeat (4) @(posedge mclk);
		chk({31'h0, busy}, 32'h0);
		req_code <= code;
		k = 0;
		while (busy !== 1'b1 && k < 20) begin
			@(posedge mclk);
			#1 k++;
		end
		chk({31'h0, busy}, 32'h1);
		@(posedge mclk);
		req_go <= 1'b0;
		chk(per_in_address, {4'h8, 6'h0, c.port_lo, 2'h0});
		k = 0;
		while ((busy | per_out_valid) !== 1'b0 && k < 200) begin
			@(posedge mclk);
			#1 k++;
		end
		chk(32'(k < 200), 32'h1);
		wr({ch, dma_cfg_pkg::OFS_CONTROL}, 32'h0);
		if (code[0] == 1'b0) begin
			chk(oq.size(), beats);
			chk(aq.size(), beats / n);
			for (k = 0; k < aq.size(); k++)
				chk(aq[k], 32'h100 + 4 * k);
			for (k = 0; k < oq.size(); k++) begin
				lane = e ? n - 1 - k % n : k % n;
				sh = ((32'h100 + 4 * (k / n)) ^ 32'h44332211) >> (lane * 32 / n);
				chk(oq[k].data & (n == 2 ? 16'hFFFF : 16'h00FF), n == 2 ? sh[15:0] : sh[7:0]);
				chk(oq[k].address, {4'h8, 6'h0, c.port_lo, 2'h0});
				chk({31'h0, oq[k].half}, {31'h0, c.datum_width_select});
			end
		end else begin
			chk(32'(in_count - first), beats);
			chk(wq.size(), beats / n);
			for (int w = 0; w < wq.size(); w++) begin
				word = 32'h0;
				for (k = 0; k < n; k++) begin
					b = first + 8'(w * n + k);
					lane = e ? n - 1 - k : k;
					word |= (n == 2 ? {16'h0, 8'hA5, b} : {24'h0, b}) << (lane * 32 / n);
				end
				chk(wq[w], word);
				chk(aq[w], 32'h100 + 4 * w);
			end
		end
	endtask: burst

	initial begin
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		check_regs();
		check_lock();
		for (int i = 0; i < 16; i++)
			burst(4'(i), i[1]);
		give_verdict();
	end
endmodule: testbench
